// >>> hdl/bus_seq_pkg.sv
/*
  Constants and types shared by the bus transaction sequencer.
  Assumes a 25 MHz processor bus clock; one bus cycle is one clock.
*/
package bus_seq_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS      = 40;
  localparam int REFRESH_PERIOD_NS  = 15600;
  localparam int REFRESH_CYC        = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REF_TMR_W          = 9;

  // Cycle counts after the address cycle (pre = strobe high, data = strobe low)
  localparam logic [3:0] MEM_DATA_CYC   = 4'h2;
  localparam logic [3:0] BURST_DATA_CYC = 4'h4;
  localparam logic [3:0] IO_DATA_CYC    = 4'h3;
  localparam logic [3:0] IACK_PRE_CYC   = 4'h2;
  localparam logic [3:0] IACK_DATA_CYC  = 4'h2;
  localparam logic [3:0] NODATA_PRE_CYC = 4'h2;
  localparam logic [3:0] E2M_DATA_CYC   = 4'h4;
  localparam logic [3:0] M2E_DATA_CYC   = 4'h2;
  localparam logic [1:0] BURST_LAST     = 2'h3;
  localparam logic [4:0] IO_MIN_LEN     = 5'h04;
  localparam logic [4:0] IACK_MIN_LEN   = 5'h05;

  // ==========================================================
  // Transaction type codes
  localparam logic [3:0] TT_REFRESH = 4'h1;
  localparam logic [3:0] TT_IO      = 4'h2;
  localparam logic [3:0] TT_HALT    = 4'h3;
  localparam logic [3:0] TT_IACK_A  = 4'h4;
  localparam logic [3:0] TT_IACK_N  = 4'h5;
  localparam logic [3:0] TT_IACK_B  = 4'h6;
  localparam logic [3:0] TT_IACK_C  = 4'h7;
  localparam logic [3:0] TT_MEM     = 4'h8;
  localparam logic [3:0] TT_EPU_MEM = 4'hA;
  localparam logic [3:0] TT_TMPL_NX = 4'hC;
  localparam logic [3:0] TT_TMPL_1  = 4'hD;
  localparam logic [3:0] TT_EPU_CPU = 4'hE;

  localparam logic [7:0] IO_PAGE_ONCHIP = 8'hFE;  // FE and FF both on chip

  // Requests from the core; refresh, acknowledge and burst are made by the sequencer itself
  typedef enum logic [3:0] {
    K_MEM_RD, K_MEM_WR, K_FETCH, K_TMPL_FIRST, K_TMPL_NEXT, K_HALT,
    K_IO_RD, K_IO_WR, K_EPU_TO_MEM, K_MEM_TO_EPU, K_EPU_CPU_RD,
    K_EPU_CPU_WR, K_REFRESH, K_IACK, K_BURST
  } kind_t;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PRE, S_DATA, S_GAP, S_BEAT
  } state_t;

endpackage

// >>> hdl/pin_sync3.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes inputs are asynchronous to clk; output moves only when stages two
  and three agree.
*/
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } sync_t;

  sync_t q;
  sync_t d;

  // ==========================================================
  // Stage one feeds only stage two
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= {INIT, INIT, INIT, INIT};
    end else begin
      q <= d;
    end
  end

  assign dout = q.o;
endmodule

// >>> hdl/bus_seq.sv
/*
  Bus transaction sequencer for a multiplexed address/data processor bus.
  Assumes a core that issues one request at a time, a responder that
  stretches with wait_n, and coprocessor units that watch the type lines.
*/
`timescale 1ns/100ps
module bus_seq
  import bus_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        req_valid,
  input  wire kind_t       req_kind,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        req_byte,
  input  wire logic        burst_half_ok,
  input  wire logic        mux_mode,
  input  wire logic [2:0]  mem_waits,
  input  wire logic [2:0]  io_waits,
  input  wire logic        instr_last,
  input  wire logic [2:0]  int_enable,
  input  wire logic [2:0]  int_req_n,
  input  wire logic        nmi_n,
  input  wire logic        pause,
  input  wire logic        wait_n,
  input  wire logic [15:0] ad_i,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_internal,
  output logic             rsp_iack,
  output logic             address_strobe_n,
  output logic             data_strobe_n,
  output logic [3:0]       transaction_type_lines,
  output logic             rw,
  output logic             bw,
  output logic [15:0]      ad_o,
  output logic             ad_oe,
  output logic [7:0]       addr_hi
);

  typedef struct packed {
    state_t               st;
    kind_t                kind;
    logic [3:0]           cnt;
    logic [3:0]           dlen;
    logic [1:0]           beat;
    logic [23:0]          addr;
    logic [15:0]          wdata;
    logic                 byte_sel;
    logic [REF_TMR_W-1:0] ref_tmr;
    logic [9:0]           ref_row;
    logic                 ref_pend;
    logic                 ack_pend;
    logic [3:0]           ack_code;
    logic                 nmi_seen;
    logic [4:0]           len;
    logic                 ready;
    logic                 rsp_v;
    logic [15:0]          rsp_d;
    logic                 rsp_int;
    logic                 rsp_ack;
    logic                 as_n;
    logic                 ds_n;
    logic [3:0]           tt;
    logic                 rw;
    logic                 bw;
    logic [15:0]          ad;
    logic                 oe;
  } seq_t;

  seq_t q;
  seq_t d;

  logic       nmi_tog_q;
  logic [5:0] sync_o;
  logic       wait_s;
  logic       pause_s;
  logic       nmi_tog_s;
  logic [2:0] irq_s_n;
  logic       nmi_lat;

  // ==========================================================
  // Edge capture on the nonmaskable pin: a toggle survives even a glitch
  // shorter than a clock, which a sampled level would miss
  always_ff @(negedge nmi_n or negedge rstn) begin
    if (!rstn) begin
      nmi_tog_q <= 1'b0;
    end else begin
      nmi_tog_q <= ~nmi_tog_q;
    end
  end

  pin_sync3 #(.W(6), .INIT(6'h39)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({int_req_n, nmi_tog_q, pause, wait_n}),
    .dout (sync_o)
  );

  assign wait_s    = sync_o[0];
  assign pause_s   = sync_o[1];
  assign nmi_tog_s = sync_o[2];
  assign irq_s_n   = sync_o[5:3];
  assign nmi_lat   = nmi_tog_s != q.nmi_seen;  // Latch stays set until acknowledged

  // ==========================================================
  // Lane helpers; words travel byte-swapped on the multiplexed lines
  function automatic logic [15:0] lanes_out(input logic [15:0] w, input logic byte_sel,
                                            input logic is_io);
    if (!byte_sel) begin
      lanes_out = {w[7:0], w[15:8]};
    end else if (is_io) begin
      lanes_out = {8'h00, w[7:0]};
    end else begin
      lanes_out = {w[7:0], w[7:0]};
    end
  endfunction

  function automatic logic [15:0] lanes_in(input logic [15:0] v, input logic byte_sel,
                                           input logic is_io, input logic a0);
    if (!byte_sel) begin
      lanes_in = {v[7:0], v[15:8]};
    end else if (is_io || a0) begin
      lanes_in = {8'h00, v[7:0]};
    end else begin
      lanes_in = {8'h00, v[15:8]};
    end
  endfunction

  function automatic logic is_io_kind(input kind_t k);
    is_io_kind = (k == K_IO_RD) || (k == K_IO_WR);
  endfunction

  // ==========================================================
  // Sequencer
  always_comb begin
    logic go;
    logic drive_wr;
    logic rd_kind;
    logic wait_used;
    logic [3:0] pre;
    kind_t k;
    go        = 1'b0;
    pre       = 4'h0;
    k         = req_kind;
    d         = q;
    d.rsp_v   = 1'b0;
    d.rsp_int = 1'b0;
    d.rsp_ack = 1'b0;
    drive_wr  = (q.kind == K_MEM_WR) || (q.kind == K_IO_WR) || (q.kind == K_EPU_CPU_WR);
    rd_kind   = (q.kind == K_MEM_RD) || (q.kind == K_FETCH) || (q.kind == K_BURST) ||
                (q.kind == K_TMPL_FIRST) || (q.kind == K_TMPL_NEXT) ||
                (q.kind == K_IO_RD) || (q.kind == K_EPU_CPU_RD) || (q.kind == K_IACK);
    wait_used = (q.kind != K_HALT) && (q.kind != K_REFRESH);
    if (q.st != S_IDLE) begin
      d.len = q.len + 5'h01;
    end

    // Refresh timer runs regardless of halt or pause
    if (q.ref_tmr == REF_TMR_W'(REFRESH_CYC - 1)) begin
      d.ref_tmr  = '0;
      d.ref_pend = 1'b1;
    end else begin
      d.ref_tmr = q.ref_tmr + 1'b1;
    end

    // Interrupt sampling at the start of the final instruction cycle
    if (instr_last && !q.ack_pend) begin
      if (nmi_lat) begin
        d.ack_pend = 1'b1;
        d.ack_code = TT_IACK_N;
      end else if (!irq_s_n[0] && int_enable[0]) begin
        d.ack_pend = 1'b1;
        d.ack_code = TT_IACK_A;
      end else if (!irq_s_n[1] && int_enable[1]) begin
        d.ack_pend = 1'b1;
        d.ack_code = TT_IACK_B;
      end else if (!irq_s_n[2] && int_enable[2]) begin
        d.ack_pend = 1'b1;
        d.ack_code = TT_IACK_C;
      end
    end

    case (q.st)
      S_IDLE: begin
        d.ds_n = 1'b1;
        d.oe   = 1'b0;
        if (q.ref_pend) begin
          // Refresh may start straight after any transaction's last cycle
          go         = 1'b1;
          k          = K_REFRESH;
          // A timer tick landing in this same cycle must not be lost
          d.ref_pend = (q.ref_tmr == REF_TMR_W'(REFRESH_CYC - 1));
          d.ref_row  = q.ref_row + 10'h001;
          d.addr     = {14'h0000, q.ref_row};
          d.tt       = TT_REFRESH;
          pre        = NODATA_PRE_CYC;
        end else if (q.ack_pend && !pause_s) begin
          go         = 1'b1;
          k          = K_IACK;
          d.ack_pend = 1'b0;
          d.tt       = q.ack_code;
          d.addr     = '0;
          pre        = IACK_PRE_CYC + {1'b0, io_waits};
          d.dlen     = IACK_DATA_CYC;
          if (q.ack_code == TT_IACK_N) begin
            d.nmi_seen = nmi_tog_s;
          end
        end else if (q.ready && req_valid) begin
          d.addr     = req_addr;
          d.wdata    = req_wdata;
          d.byte_sel = req_byte;
          if (is_io_kind(req_kind) && req_addr[23:17] == IO_PAGE_ONCHIP[7:1]) begin
            d.rsp_v   = 1'b1;
            d.rsp_int = 1'b1;
            d.rsp_d   = '0;
          end else begin
            go = 1'b1;
            case (req_kind)
              K_FETCH: begin
                if (burst_half_ok && mux_mode) begin
                  k          = K_BURST;
                  d.addr     = {req_addr[23:3], 3'b000};
                  d.byte_sel = 1'b0;
                  d.dlen     = BURST_DATA_CYC + {1'b0, mem_waits};
                end else begin
                  d.dlen = MEM_DATA_CYC + {1'b0, mem_waits};
                end
                d.tt = TT_MEM;
              end
              K_TMPL_FIRST: begin
                d.tt   = TT_TMPL_1;
                d.dlen = MEM_DATA_CYC + {1'b0, mem_waits};
              end
              K_TMPL_NEXT: begin
                d.tt   = TT_TMPL_NX;
                d.dlen = MEM_DATA_CYC + {1'b0, mem_waits};
              end
              K_HALT: begin
                d.tt = TT_HALT;
                pre  = NODATA_PRE_CYC;
              end
              K_IO_RD, K_IO_WR: begin
                d.tt   = TT_IO;
                d.dlen = IO_DATA_CYC + {1'b0, io_waits};
              end
              K_EPU_TO_MEM: begin
                d.tt   = TT_EPU_MEM;
                d.dlen = E2M_DATA_CYC;
              end
              K_MEM_TO_EPU: begin
                d.tt   = TT_EPU_MEM;
                d.dlen = M2E_DATA_CYC;
              end
              K_EPU_CPU_RD, K_EPU_CPU_WR: begin
                d.tt   = TT_EPU_CPU;
                d.dlen = IO_DATA_CYC;
              end
              default: begin
                d.tt   = TT_MEM;
                d.dlen = MEM_DATA_CYC + {1'b0, mem_waits};
              end
            endcase
          end
        end
        if (go) begin
          // Address cycle: strobe low, type and direction valid at its rise
          d.st   = S_ADDR;
          d.kind = k;
          d.cnt  = pre;
          d.len  = 5'h01;
          d.beat = 2'h0;
          d.as_n = 1'b0;
          d.rw   = !((k == K_MEM_WR) || (k == K_IO_WR) || (k == K_EPU_TO_MEM) ||
                     (k == K_EPU_CPU_WR));
          d.bw   = (k == K_REFRESH || k == K_HALT || k == K_IACK || k == K_BURST) ?
                   1'b0 : req_byte;
          d.ad   = d.addr[15:0];
          d.oe   = (k != K_EPU_CPU_RD) && (k != K_EPU_CPU_WR);
        end
      end
      S_ADDR: begin
        d.as_n = 1'b1;
        d.oe   = 1'b0;
        if (q.cnt != 4'h0) begin
          d.st = S_PRE;
        end else begin
          d.st   = S_DATA;
          d.cnt  = q.dlen;
          d.ds_n = 1'b0;
          d.oe   = drive_wr;
          d.ad   = lanes_out(q.wdata, q.byte_sel, is_io_kind(q.kind));
        end
      end
      S_PRE: begin
        if (q.cnt > 4'h1) begin
          d.cnt = q.cnt - 4'h1;
        end else if (q.kind == K_IACK && !wait_s) begin
          d.st = S_PRE;
        end else if (q.kind == K_IACK) begin
          d.st   = S_DATA;
          d.cnt  = q.dlen;
          d.ds_n = 1'b0;
        end else begin
          d.st = S_IDLE;  // halt and refresh never lower the data strobe
        end
      end
      S_DATA: begin
        if (q.cnt > 4'h1) begin
          d.cnt = q.cnt - 4'h1;
        end else if (wait_used && !wait_s) begin
          d.st = S_DATA;
        end else begin
          d.ds_n    = 1'b1;
          d.oe      = 1'b0;
          d.rsp_v   = 1'b1;
          d.rsp_ack = q.kind == K_IACK;
          d.rsp_d   = rd_kind ? lanes_in(ad_i, q.byte_sel, is_io_kind(q.kind), q.addr[0]) :
                      16'h0000;
          d.st      = (q.kind == K_BURST) ? S_GAP : S_IDLE;
        end
      end
      S_GAP: begin
        d.ds_n = 1'b0;  // Later burst beats take no automatic waits
        d.st   = S_BEAT;
        d.beat = q.beat + 2'h1;
      end
      S_BEAT: begin
        d.ds_n  = 1'b1;
        d.rsp_v = 1'b1;
        d.rsp_d = lanes_in(ad_i, 1'b0, 1'b0, 1'b0);
        d.st    = (q.beat == BURST_LAST) ? S_IDLE : S_GAP;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase

    // New work only from idle, and not while a coprocessor holds pause
    d.ready = (d.st == S_IDLE) && !go && !d.ref_pend && !d.ack_pend && !pause_s;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.st    <= S_IDLE;
      q.kind  <= K_MEM_RD;
      q.as_n  <= 1'b1;
      q.ds_n  <= 1'b1;
      q.rw    <= 1'b1;
      q.bw    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Every output straight from a flip-flop
  assign req_ready              = q.ready;
  assign rsp_valid              = q.rsp_v;
  assign rsp_data               = q.rsp_d;
  assign rsp_internal           = q.rsp_int;
  assign rsp_iack               = q.rsp_ack;
  assign address_strobe_n       = q.as_n;
  assign data_strobe_n          = q.ds_n;
  assign transaction_type_lines = q.tt;
  assign rw                     = q.rw;
  assign bw                     = q.bw;
  assign ad_o                   = q.ad;
  assign ad_oe                  = q.oe;
  assign addr_hi                = q.addr[23:16];

  // ==========================================================
  // Checks
  halt_no_strobe_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.kind == K_HALT && q.st != S_IDLE) |-> q.ds_n && q.tt == TT_HALT)
    else $error("halt transaction lowered the data strobe");
  onchip_io_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.st == S_ADDR && q.tt == TT_IO) |-> q.addr[23:17] != IO_PAGE_ONCHIP[7:1])
    else $error("on-chip I/O page went to the bus");
  burst_align_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.st == S_ADDR && q.kind == K_BURST) |-> q.ad[2:0] == 3'b000 && mux_mode)
    else $error("burst address not aligned or wrong mode");
  strobe_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(q.as_n) |=> q.as_n ##1 q.as_n)
    else $error("address strobe not a one-cycle pulse");
  epu_float_a: assert property (@(posedge clk) disable iff (!rstn)
    (!q.ds_n && q.tt == TT_EPU_MEM) |-> !q.oe)
    else $error("lines driven during coprocessor memory transfer");
  wait_stretch_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.st == S_DATA && q.cnt == 4'h1 && !wait_s && q.kind != K_HALT) |=> !q.ds_n)
    else $error("wait low did not stretch the data cycle");
  pause_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    pause_s |=> !q.ready)
    else $error("ready offered while paused");
  io_length_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.tt == TT_IO && q.st == S_DATA && q.cnt == 4'h1 && wait_s) |-> q.len >= IO_MIN_LEN - 5'h1)
    else $error("I/O transaction too short");
  iack_length_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.kind == K_IACK && q.st == S_DATA && q.cnt == 4'h1 && wait_s) |->
      q.len >= IACK_MIN_LEN - 5'h1)
    else $error("acknowledge transaction too short");
  refresh_row_a: assert property (@(posedge clk) disable iff (!rstn)
    (q.st == S_ADDR && q.kind == K_REFRESH) |-> q.ad[9:0] == q.ref_row - 10'h001)
    else $error("refresh row not on low lines");

endmodule

// >>> tb/bus_responder.sv
/*
  Far-side model: memory and peripherals on the bus.
  Assumes it sees only the sequencer's strobes, read/write and lanes.
*/
`timescale 1ns/100ps
module bus_responder (
  input  wire logic        clk,
  input  wire logic        address_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        rw,
  input  wire logic [15:0] ad_o,
  input  wire logic [2:0]  slow,
  output logic      [15:0] ad_i,
  output logic             wait_n
);
  logic [15:0] a_q = 16'h0000;
  logic [2:0]  w_q = 3'h0;
  // ============================================================
  // Lanes: data only under a read strobe, else a toggling pattern
  initial ad_i = 16'h0000;
  always @(posedge clk) begin
    if (!address_strobe_n)
      a_q <= ad_o;
    if (!data_strobe_n && rw)
      ad_i <= #2 a_q ^ 16'hA5C3;
    else
      ad_i <= #2 ~ad_i;
    // Wait raised early: the sequencer only sees it four flops later
    if (data_strobe_n)
      w_q <= slow;
    else if (w_q != 3'h0)
      w_q <= w_q - 3'h1;
  end
  assign wait_n = (w_q == 3'h0);
endmodule

// >>> tb/tb.sv
/*
  Self-checking bench for the bus sequencer with a responder model.
  Assumes the package and the responder are compiled first.
*/
`timescale 1ns/100ps
module tb
  import bus_seq_pkg::*;
;
  logic        clk, rstn, req_valid, req_byte, burst_half_ok, mux_mode, instr_last;
  logic        nmi_n, pause, wait_n, req_ready, rsp_valid, rsp_internal, rsp_iack;
  logic        address_strobe_n, data_strobe_n, rw, bw, ad_oe, rw_s, bw_s;
  kind_t       req_kind;
  logic [23:0] req_addr, a;
  logic [15:0] req_wdata, ad_i, ad_o, rsp_data, ad_s, wd_s, rd_s;
  logic [2:0]  mem_waits, io_waits, int_enable, int_req_n, slow;
  logic [3:0]  transaction_type_lines, tt_s;
  logic [7:0]  addr_hi, hi_s;
  logic [9:0]  row_q;
  int          error_cnt = 0, comparisons = 0, ref_c = 0, bad_c = 0, cyc = 0;
  int          as_c, ds_c, rv_c, in_c, ak_c, seed, i, n, r0;
  kind_t       ks [5] = '{K_MEM_TO_EPU, K_EPU_TO_MEM, K_EPU_CPU_RD, K_EPU_CPU_WR, K_TMPL_NEXT};
  logic [3:0]  ts [5] = '{TT_EPU_MEM, TT_EPU_MEM, TT_EPU_CPU, TT_EPU_CPU, TT_TMPL_NX};
  logic [3:0]  it [4] = '{TT_IACK_N, TT_IACK_A, TT_IACK_B, TT_IACK_C};

  bus_seq i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_byte(req_byte),
    .burst_half_ok(burst_half_ok), .mux_mode(mux_mode), .mem_waits(mem_waits),
    .io_waits(io_waits), .instr_last(instr_last), .int_enable(int_enable),
    .int_req_n(int_req_n), .nmi_n(nmi_n), .pause(pause), .wait_n(wait_n), .ad_i(ad_i),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_internal(rsp_internal), .rsp_iack(rsp_iack), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .transaction_type_lines(transaction_type_lines),
    .rw(rw), .bw(bw), .ad_o(ad_o), .ad_oe(ad_oe), .addr_hi(addr_hi));
  bus_responder i_rsp (.clk(clk), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .rw(rw), .ad_o(ad_o), .slow(slow), .ad_i(ad_i),
    .wait_n(wait_n));

  // ============================================================
  // Clock, cycle ceiling and closing report
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Counts: comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ============================================================
  // Bus watcher; refresh kept apart so it never hides a transaction
  always @(posedge clk) begin
    if (!address_strobe_n && transaction_type_lines == TT_REFRESH) begin
      if (ref_c > 0)
        chk(ad_o[9:0], row_q + 10'h001);
      row_q <= ad_o[9:0];
      ref_c <= ref_c + 1;
    end else if (!address_strobe_n) begin
      as_c <= as_c + 1;
      tt_s <= transaction_type_lines;
      rw_s <= rw;
      bw_s <= bw;
      ad_s <= ad_o;
      hi_s <= addr_hi;
    end
    if (!data_strobe_n)
      ds_c <= ds_c + 1;
    if (!data_strobe_n && !rw)
      wd_s <= ad_o;
    if (!data_strobe_n && ad_oe && transaction_type_lines == TT_EPU_MEM)
      bad_c <= bad_c + 1;
    if (rsp_valid) begin
      rv_c <= rv_c + 1;
      rd_s <= rsp_data;
      in_c <= in_c + int'(rsp_internal);
      ak_c <= ak_c + int'(rsp_iack);
    end
  end

  // Expected read value: responder pattern, swapped word or picked byte
  function automatic logic [15:0] exp_rd(input logic [23:0] ad, input logic b);
    logic [15:0] d;
    d = ad[15:0] ^ 16'hA5C3;
    if (!b)
      return {d[7:0], d[15:8]};
    return {8'h00, (ad[0] ? d[7:0] : d[15:8])};
  endfunction

  // One core request, held until taken, then run to idle
  task automatic run(input kind_t k, input logic [23:0] ad, input logic [15:0] w,
                     input logic b);
    @(posedge clk);
    #2 req_kind = k;
    req_addr = ad;
    req_wdata = w;
    req_byte = b;
    req_valid = 1'b1;
    as_c = 0;
    ds_c = 0;
    rv_c = 0;
    in_c = 0;
    n = 0;
    do @(posedge clk); while (!req_ready);
    #2 req_valid = 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!req_ready && n < 300);
    repeat (2) @(posedge clk);
    chk(n < 300, 1'b1);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    seed = 90634;
    {req_valid, req_byte, burst_half_ok, mux_mode, instr_last, pause} = '0;
    {rstn, nmi_n} = 2'b01;
    {mem_waits, io_waits, slow} = '0;
    int_enable = 3'h7;
    int_req_n = 3'h7;
    req_kind = K_MEM_RD;
    {req_addr, req_wdata} = '0;
    repeat (4) @(posedge clk);
    #2 rstn = 1'b1;
    for (i = 0; i < 12; i++) begin
      a = 24'($random(seed));
      slow = (i > 7) ? 3'h3 : 3'h0;
      run(K_MEM_RD, a, 16'h0000, i[0]);
      chk(tt_s, TT_MEM);
      chk({rw_s, bw_s, ad_s}, {1'b1, i[0], a[15:0]});
      chk(i[0] ? {8'h00, rd_s[7:0]} : rd_s, exp_rd(a, i[0]));
      chk(ds_c > 2, slow != 3'h0);
    end
    $display("Test memory reads done");
    // Responder back to zero wait before the fixed-length checks below
    #2 slow = 3'h0;
    for (i = 0; i < 2; i++) begin
      run(K_MEM_WR, a, 16'($random(seed)), i[0]);
      chk({tt_s, rw_s, bw_s}, {TT_MEM, 1'b0, i[0]});
      chk(wd_s, i[0] ? {2{req_wdata[7:0]}} : {req_wdata[7:0], req_wdata[15:8]});
    end
    $display("Test memory writes done");
    for (i = 0; i < 8; i++) begin
      a = {1'b0, 23'($random(seed))};
      io_waits = {1'b0, i[2:1]};
      run(i[0] ? K_IO_WR : K_IO_RD, a, 16'($random(seed)), i[1]);
      chk({tt_s, hi_s, ad_s}, {TT_IO, a[23:16], a[15:0]});
      chk(ds_c, IO_DATA_CYC + io_waits);
      if (i[0])
        chk(i[1] ? wd_s[7:0] : wd_s,
            i[1] ? req_wdata[7:0] : {req_wdata[7:0], req_wdata[15:8]});
      run(K_IO_RD, {7'h7F, i[0], 16'($random(seed))}, 16'h0000, 1'b1);
      chk({as_c, in_c}, {32'h0, 32'h1});
    end
    $display("Test input output done");
    {burst_half_ok, mux_mode} = 2'b11;
    run(K_FETCH, 24'($random(seed)), 16'h0000, 1'b0);
    chk({rv_c, ad_s[2:0]}, {8'h04, 3'h0});
    run(K_TMPL_FIRST, 24'($random(seed)), 16'h0000, 1'b0);
    chk({rv_c, tt_s}, {8'h01, TT_TMPL_1});
    mux_mode = 1'b0;
    run(K_FETCH, 24'($random(seed)), 16'h0000, 1'b0);
    chk(rv_c, 1);
    for (i = 0; i < 5; i++) begin
      run(ks[i], 24'($random(seed)), 16'($random(seed)), 1'b0);
      chk({as_c, tt_s}, {8'h01, ts[i]});
    end
    chk(bad_c, 0);
    $display("Test burst and coprocessor done");
    for (i = 0; i < 4; i++) begin
      ak_c = 0;
      ds_c = 0;
      if (i == 0)
        nmi_n = 1'b0;
      else
        int_req_n[i-1] = 1'b0;
      #10 nmi_n = 1'b1;
      repeat (6) @(posedge clk);
      #2 instr_last = 1'b1;
      @(posedge clk);
      #2 instr_last = 1'b0;
      n = 0;
      while (ak_c == 0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk({ak_c, tt_s}, {8'h01, it[i]});
      chk(ds_c, IACK_DATA_CYC);
      #2 int_req_n = 3'h7;
      repeat (4) @(posedge clk);
    end
    $display("Test acknowledge done");
    #2 pause = 1'b1;
    repeat (6) @(posedge clk);
    fork
      run(K_MEM_RD, 24'h000010, 16'h0000, 1'b0);
      begin
        repeat (20) @(posedge clk);
        chk(as_c, 0);
        #2 pause = 1'b0;
      end
    join
    chk(rv_c, 1);
    slow = 3'h5;
    a = 24'($random(seed));
    run(K_HALT, a, 16'h0000, 1'b0);
    chk({tt_s, ds_c, ad_s}, {TT_HALT, 32'h0, a[15:0]});
    slow = 3'h0;
    r0 = ref_c;
    repeat (400) @(posedge clk);
    chk(ref_c > r0, 1'b1);
    $display("Test pause halt refresh done");
    complete_run();
  end
endmodule
